// *** mdsq_pkg.sv ***
// constants and types shared by the multichannel output sequencer
package mdsq_pkg;
    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int MDSQ_BUF_ADDR_W = 23;          // 8M words
    localparam int MDSQ_PAGE_ADDR_W = 22;         // 4M words per page
    localparam int MDSQ_WORD_W = 32;
    // ------------------------------------------------------------
    // word layout: [31:28] channel, [23:0] sample
    // ------------------------------------------------------------
    localparam int MDSQ_CHAN_LSB = 28;
    localparam int MDSQ_DATA_W = 24;
    localparam int MDSQ_DOUT_OE_LO_BIT = 16;      // low byte enable
    localparam int MDSQ_DOUT_OE_HI_BIT = 17;      // high byte enable
    localparam logic [3:0] MDSQ_CHAN_DOUT = 4'h9;
    // ------------------------------------------------------------
    // generators and outputs
    // ------------------------------------------------------------
    localparam int MDSQ_NUM_GEN = 4;
    localparam int MDSQ_NUM_CONV = 8;
    localparam int MDSQ_PHASE_W = 32;
    localparam int MDSQ_SEL_W = 4;                // 0 buffer, 1..4 sin, 5..8 cos
    localparam int MDSQ_GROUP_DELAY = 29;         // conversion periods
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MDSQ_CLOCK_HZ = 10_000_000;
    localparam int MDSQ_RATE_MIN_HZ = 24_000;
    localparam int MDSQ_RATE_MAX_HZ = 192_000;
    localparam int MDSQ_RATE_RESET_HZ = 192_000;
    localparam int MDSQ_DOUT_OE_DELAY_NS = 50;
    localparam int MDSQ_DOUT_OE_DELAY_CYC =
        (MDSQ_DOUT_OE_DELAY_NS * (MDSQ_CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [23:0] MDSQ_ZERO_LEVEL = 24'h00_0000;
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MDSQ_IDLE,
        MDSQ_FETCH,
        MDSQ_LOAD
    } mdsq_state_t;
endpackage

// *** mdsq_sequencer.sv ***
// output sequencer: sample buffer, routing, generators, correction
//
// Behaviour
// RULE1 - 8M x 32 buffer, ring or streaming
// RULE2 - ring: two 4M pages, play one, fill other
// RULE3 - page swap only at playing page start
// RULE4 - streaming uses whole buffer as FIFO
// RULE5 - holding registers keep last value when empty
// RULE6 - each word carries channel 1..9 plus data
// RULE7 - channel 1..8 to converters, 9 to digital
// RULE8 - update strobe on programmed trigger channel
// RULE9 - four generators step once per period
// RULE10 - 32-bit phase, 24-bit sine and cosine
// RULE11 - frequency change accepted any time, no stop
// RULE12 - per-output source: buffer or any generator
// RULE13 - host keeps all buffer channels one mode
// RULE14 - per-converter scale and offset correction
// RULE15 - rate 24..192 kHz in 1 Hz steps
// RULE16 - host limits its streaming rate
// RULE17 - after reset converters zero, digital high-Z
// RULE18 - digital high-Z control per 8-pin group
// RULE19 - digital channel updates on same strobe
// RULE20 - converter samples are 24 bits
// RULE21 - variant drives 16-bit digital output
// RULE22 - two enable bits per digital word
// RULE23 - converter lag 29 periods, software compensates
// RULE24 - flag underrun and overflow in streaming
`timescale 1ns/100ps
module mdsq_sequencer
    import mdsq_pkg::*;
#(
    parameter int ADDR_W = MDSQ_BUF_ADDR_W,
    parameter int DOUT_W = 8,
    parameter int RATE_ACC_W = 24
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // sample writes from controller
    input wire logic i_wr_valid,
    input wire logic [MDSQ_WORD_W-1:0] i_wr_data,
    // mode and commands
    input wire logic i_ring_mode,
    input wire logic i_run,
    input wire logic i_page_change,
    input wire logic [ADDR_W-2:0] i_ring_length,
    input wire logic [3:0] i_trig_chan,
    input wire logic [17:0] i_rate_hz,
    // generator settings
    input wire logic [MDSQ_NUM_GEN-1:0] i_gen_load,
    input wire logic [MDSQ_PHASE_W-1:0] i_gen_phase,
    input wire logic [MDSQ_PHASE_W-1:0] i_gen_step,
    // output source and correction
    input wire logic [9*MDSQ_SEL_W-1:0] i_src_sel,
    input wire logic [MDSQ_NUM_CONV*16-1:0] i_scale,
    input wire logic [MDSQ_NUM_CONV*MDSQ_DATA_W-1:0] i_offset,
    // converter and digital outputs
    output logic [MDSQ_NUM_CONV*MDSQ_DATA_W-1:0] o_conv_data,
    output logic o_conv_update,
    output logic [DOUT_W-1:0] o_dout,
    output logic [DOUT_W/8-1:0] o_dout_oe_n,
    // status
    output logic o_page_playing,
    output logic o_wr_ready,
    output logic o_underrun,
    output logic o_overflow
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DOUT_W != 8 && DOUT_W != 16) begin : g_bad_dout
        $error("DOUT_W must be 8 or 16");
    end
    if (ADDR_W < 4 || ADDR_W > MDSQ_BUF_ADDR_W) begin : g_bad_addr
        $error("ADDR_W out of range");
    end
    // the divider sum must fit, or ticks would be lost to wrap
    if ((64'h1 << RATE_ACC_W) <= 64'(MDSQ_CLOCK_HZ + MDSQ_RATE_MAX_HZ)) begin : g_bad_rate
        $error("RATE_ACC_W too narrow for the divider");
    end

    localparam int NG = DOUT_W / 8;             // enable groups
    localparam int DW = MDSQ_DATA_W;

    // sample memory, 32-bit words (see RULE1)
    logic [MDSQ_WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [MDSQ_WORD_W-1:0] mem_q;

    // ------------------------------------------------------------
    // generator sine lookup (quarter-wave free, coarse table)
    // ------------------------------------------------------------
    function automatic logic signed [DW-1:0] sine_of(input logic [MDSQ_PHASE_W-1:0] ph);
        logic [5:0] idx;
        logic signed [DW-1:0] x;
        logic signed [2*DW-1:0] sq;
        logic [DW:0] mag;
        logic signed [DW-1:0] pos;
        idx = ph[MDSQ_PHASE_W-1 -: 6];
        // parabola over each half wave, zero at its ends, good to a few percent
        x = DW'(signed'({1'b0, idx[4:0], 18'h0_0000})) - DW'(24'h40_0000);
        // square kept at full width, a narrow product would wrap to garbage
        sq = x * x;
        mag = (DW+1)'(25'h80_0000) - (DW+1)'(sq >>> 21);
        // the crest would overflow by one code, so it is clipped
        pos = mag[DW-1] ? DW'(24'h7F_FFFF) : DW'(mag);
        sine_of = idx[5] ? -pos : pos;
    endfunction

    // source selection decode, used for all nine outputs (see RULE12)
    function automatic logic [DW-1:0] pick(input logic [MDSQ_SEL_W-1:0] sel,
                                           input logic [DW-1:0] hold,
                                           input logic [MDSQ_NUM_GEN*DW-1:0] s,
                                           input logic [MDSQ_NUM_GEN*DW-1:0] c);
        pick = hold;
        if (sel >= 4'h1 && sel <= 4'h4) begin
            pick = s[(sel-4'h1)*DW +: DW];
        end else if (sel >= 4'h5 && sel <= 4'h8) begin
            pick = c[(sel-4'h5)*DW +: DW];
        end
    endfunction

    // ------------------------------------------------------------
    // all module state except the sample memory and its read register mem_q in one struct
    // ------------------------------------------------------------
    typedef struct packed {
        mdsq_state_t state;
        logic [ADDR_W-1:0] wr_ptr;                 // write address
        logic [ADDR_W-1:0] rd_ptr;                 // read address
        logic [ADDR_W:0] count;                    // fifo fill
        logic play_page;                           // ring page being replayed
        logic swap_pending;                        // page change waiting
        logic [RATE_ACC_W-1:0] rate_acc;           // conversion tick divider
        logic [MDSQ_NUM_GEN*MDSQ_PHASE_W-1:0] phase;
        logic [MDSQ_NUM_GEN*MDSQ_PHASE_W-1:0] step;
        logic [9*DW-1:0] hold;                     // buffer holding registers
        logic [MDSQ_NUM_CONV*DW-1:0] conv;
        logic update;
        logic [DOUT_W-1:0] dout;
        logic [NG-1:0] oe_want;                    // enables from word
        logic [NG-1:0] oe_n;
        logic [3:0] oe_dly;                        // enable lag counter
        logic underrun;
        logic overflow;
    } mdsq_regs_t;

    mdsq_regs_t st_reg, st_next;
    logic tick;
    logic [ADDR_W-1:0] wr_addr;                    // memory write address
    // generator output buses (see RULE10)
    logic [MDSQ_NUM_GEN*DW-1:0] sin_bus;
    logic [MDSQ_NUM_GEN*DW-1:0] cos_bus;

    // conversion tick: fractional divider, rate in 1 Hz steps (see RULE15)
    assign tick = (st_reg.rate_acc + RATE_ACC_W'(i_rate_hz)) >= RATE_ACC_W'(MDSQ_CLOCK_HZ);

    // accept writes unless full; ring mode writes the idle page (see RULE24)
    assign o_wr_ready = i_ring_mode || (st_reg.count < (ADDR_W+1)'(1 << ADDR_W));

    // ring writes land on the idle page from the very first word (see RULE2)
    assign wr_addr = i_ring_mode ? {~st_reg.play_page, st_reg.wr_ptr[ADDR_W-2:0]}
                                 : st_reg.wr_ptr;

    // ------------------------------------------------------------
    // memory port, written and read synchronously
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_wr_valid && o_wr_ready) begin
            mem[wr_addr] <= i_wr_data;
        end
        mem_q <= mem[st_reg.rd_ptr];
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] ch;
        logic wr_ok;
        logic rd_ok;
        logic [ADDR_W-1:0] page_base;
        logic [DW-1:0] v;
        logic [DW+15:0] prod;
        ch = mem_q[MDSQ_CHAN_LSB +: 4];
        wr_ok = i_wr_valid && o_wr_ready;
        rd_ok = 1'b0;
        page_base = {st_reg.play_page, {(ADDR_W-1){1'b0}}};
        v = '0;
        prod = '0;
        st_next = st_reg;
        st_next.update = 1'b0;
        // divider accumulates below clock rate
        st_next.rate_acc = tick ? st_reg.rate_acc + RATE_ACC_W'(i_rate_hz)
                                  - RATE_ACC_W'(MDSQ_CLOCK_HZ)
                                : st_reg.rate_acc + RATE_ACC_W'(i_rate_hz);
        // streaming overflow when a word meets a full fifo (see RULE24)
        if (i_wr_valid && !o_wr_ready) begin
            st_next.overflow = 1'b1;
        end
        // write pointer: ring fills the idle page, stream wraps whole (see RULE2)
        if (wr_ok) begin
            if (i_ring_mode) begin
                st_next.wr_ptr = {~st_reg.play_page, st_reg.wr_ptr[ADDR_W-2:0] + 1'b1};
            end else begin
                st_next.wr_ptr = st_reg.wr_ptr + 1'b1;          // see RULE4
            end
        end
        if (i_page_change) begin
            st_next.swap_pending = 1'b1;                        // see RULE3
        end
        // sequencer: each tick fetches words one by one until trigger channel
        case (st_reg.state)
            MDSQ_IDLE: begin
                if (tick && i_run) begin
                    st_next.state = MDSQ_FETCH;
                end
            end
            MDSQ_FETCH: begin
                if (i_ring_mode || st_reg.count != '0) begin
                    st_next.state = MDSQ_LOAD;
                end else begin
                    st_next.underrun = 1'b1;                    // see RULE24
                    st_next.state = MDSQ_IDLE;                  // holds keep value, see RULE5
                end
            end
            MDSQ_LOAD: begin
                rd_ok = 1'b1;
                // route by channel number (see RULE6, RULE7)
                if (ch >= 4'h1 && ch <= MDSQ_CHAN_DOUT) begin
                    st_next.hold[(ch-4'h1)*DW +: DW] = mem_q[DW-1:0];
                end
                if (ch == i_trig_chan) begin
                    st_next.update = 1'b1;                      // see RULE8
                    st_next.state = MDSQ_IDLE;
                end else begin
                    st_next.state = MDSQ_FETCH;
                end
            end
            default: begin
                st_next.state = MDSQ_IDLE;
            end
        endcase
        // read pointer advance; ring swaps only at page start (see RULE3)
        if (rd_ok) begin
            if (i_ring_mode) begin
                st_next.rd_ptr = {st_reg.play_page,
                    (st_reg.rd_ptr[ADDR_W-2:0] >= i_ring_length) ? (ADDR_W-1)'(0)
                        : st_reg.rd_ptr[ADDR_W-2:0] + 1'b1};
                if (st_next.rd_ptr == page_base && st_reg.swap_pending) begin
                    st_next.play_page = ~st_reg.play_page;
                    st_next.swap_pending = 1'b0;
                    st_next.rd_ptr = {~st_reg.play_page, {(ADDR_W-1){1'b0}}};
                    st_next.wr_ptr = {st_reg.play_page, {(ADDR_W-1){1'b0}}};
                end
            end else begin
                st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
            end
        end
        if (!i_ring_mode) begin
            st_next.count = st_reg.count + (ADDR_W+1)'(wr_ok) - (ADDR_W+1)'(rd_ok);
        end
        // generators: new load any time, step once per tick (see RULE9, RULE11)
        for (int g = 0; g < MDSQ_NUM_GEN; g++) begin
            if (i_gen_load[g]) begin
                st_next.phase[g*32 +: 32] = i_gen_phase;
                st_next.step[g*32 +: 32] = i_gen_step;
            end else if (tick) begin
                st_next.phase[g*32 +: 32] = st_reg.phase[g*32 +: 32] + st_reg.step[g*32 +: 32];
            end
        end
        // on update, select sources and correct converters (see RULE12, RULE14)
        if (st_reg.update) begin
            for (int c = 0; c < MDSQ_NUM_CONV; c++) begin
                v = pick(i_src_sel[c*MDSQ_SEL_W +: MDSQ_SEL_W], st_reg.hold[c*DW +: DW],
                         sin_bus, cos_bus);
                // operands widened first so the product keeps all its bits
                prod = (DW+16)'(signed'(v))
                     * (DW+16)'(signed'({1'b0, i_scale[c*16 +: 16]}));
                st_next.conv[c*DW +: DW] = prod[DW+14 -: DW] + i_offset[c*DW +: DW];  // see RULE20
            end
            // digital channel on the same strobe (see RULE19, RULE21)
            v = pick(i_src_sel[8*MDSQ_SEL_W +: MDSQ_SEL_W], st_reg.hold[8*DW +: DW],
                     sin_bus, cos_bus);
            st_next.dout = v[DOUT_W-1:0];
            // per-byte enables from the word (see RULE18, RULE22)
            st_next.oe_want = NG'({v[MDSQ_DOUT_OE_HI_BIT], v[MDSQ_DOUT_OE_LO_BIT]});
            st_next.oe_dly = 4'(MDSQ_DOUT_OE_DELAY_CYC);
        end else if (st_reg.oe_dly != '0) begin
            st_next.oe_dly = st_reg.oe_dly - 4'h1;
        end
        // drive-off is immediate, drive-on waits out the lag
        st_next.oe_n = (st_next.oe_dly != '0) ? (st_reg.oe_n | ~st_next.oe_want)
                                              : ~st_next.oe_want;
    end

    // generator outputs, cosine is the sine a quarter turn ahead (see RULE10)
    for (genvar g = 0; g < MDSQ_NUM_GEN; g++) begin : g_gen
        assign sin_bus[g*DW +: DW] = sine_of(st_reg.phase[g*32 +: 32]);
        assign cos_bus[g*DW +: DW] = sine_of(st_reg.phase[g*32 +: 32] + 32'h4000_0000);
    end

    // ------------------------------------------------------------
    // state register; reset gives zero outputs and high-Z pins
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '0;                               // see RULE17
            st_reg.oe_n <= '1;
            st_reg.state <= MDSQ_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs; converter lag vs digital is left to software (see RULE23)
    assign o_conv_data = st_reg.conv;
    assign o_conv_update = st_reg.update;
    assign o_dout = st_reg.dout;
    assign o_dout_oe_n = st_reg.oe_n;
    assign o_page_playing = st_reg.play_page;
    assign o_underrun = st_reg.underrun;
    assign o_overflow = st_reg.overflow;
endmodule

// *** mdsq_chk.sv ***
// assertion checker watching the output sequencer ports
`timescale 1ns/100ps
module mdsq_chk
    import mdsq_pkg::*;
#(
    parameter int ADDR_W = MDSQ_BUF_ADDR_W,
    parameter int DOUT_W = 8,
    parameter int RATE_ACC_W = 24
) (
    // clock, reset and controls
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wr_valid,
    input wire logic i_ring_mode,
    input wire logic i_run,
    input wire logic i_page_change,
    // watched outputs
    input wire logic [MDSQ_NUM_CONV*MDSQ_DATA_W-1:0] o_conv_data,
    input wire logic o_conv_update,
    input wire logic [DOUT_W-1:0] o_dout,
    input wire logic [DOUT_W/8-1:0] o_dout_oe_n,
    input wire logic o_page_playing,
    input wire logic o_wr_ready,
    input wire logic o_underrun,
    input wire logic o_overflow
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // helper: remembers an outstanding page swap request
    // ------------------------------------------------------------
    typedef struct packed { logic pend; logic page; } mdsq_chk_t;
    mdsq_chk_t st_reg;
    mdsq_chk_t st_next;
    // a swap with no request behind it is the fault we hunt
    always_comb begin
        st_next.page = o_page_playing;
        st_next.pend = (st_reg.pend || i_page_change) && (o_page_playing == st_reg.page);
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_strobe_ends;
        o_conv_update ##1 !o_conv_update;
    endsequence
    a_strobe_one_cycle: assert property (o_conv_update |-> s_strobe_ends)
        else $error("update strobe wider than one cycle");
    a_conv_hold: assert property ($changed(o_conv_data) |-> $past(o_conv_update))
        else $error("converter data moved without update strobe");
    a_dout_hold: assert property ($changed(o_dout) |-> $past(o_conv_update))
        else $error("digital data moved without update strobe");
    a_oe_lag: assert property (
        |($past(o_dout_oe_n) & ~o_dout_oe_n) |-> $past(o_conv_update, 1 + MDSQ_DOUT_OE_DELAY_CYC))
        else $error("byte drive began off its delayed slot");
    a_oe_off_now: assert property (
        |(o_dout_oe_n & ~$past(o_dout_oe_n)) |-> $past(o_conv_update))
        else $error("byte release not with its data word");
    a_underrun_sticky: assert property (o_underrun |=> o_underrun)
        else $error("underrun flag dropped");
    a_overflow_sticky: assert property (o_overflow |=> o_overflow)
        else $error("overflow flag dropped");
    a_overflow_cause: assert property (
        $rose(o_overflow) |-> $past(i_wr_valid && !o_wr_ready && !i_ring_mode))
        else $error("overflow without a refused streaming write");
    a_underrun_cause: assert property (
        $rose(o_underrun) |-> !i_ring_mode && $past(i_run))
        else $error("underrun outside streaming run");
    a_swap_requested: assert property ((o_page_playing != st_reg.page) |-> st_reg.pend)
        else $error("page swap without request");
    a_reset_quiet: assert property (
        $fell(i_rst) |-> o_conv_data == '0 && &o_dout_oe_n && !o_overflow)
        else $error("outputs not quiet after reset");
endmodule
bind mdsq_sequencer mdsq_chk #(.ADDR_W(ADDR_W), .DOUT_W(DOUT_W), .RATE_ACC_W(RATE_ACC_W)) u_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_wr_valid(i_wr_valid), .i_ring_mode(i_ring_mode),
    .i_run(i_run), .i_page_change(i_page_change), .o_conv_data(o_conv_data),
    .o_conv_update(o_conv_update), .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n),
    .o_page_playing(o_page_playing), .o_wr_ready(o_wr_ready), .o_underrun(o_underrun),
    .o_overflow(o_overflow)
);

// *** mdsq_ctl_model.sv ***
// crate controller model: queues sample words and hands them over
`timescale 1ns/100ps
module mdsq_ctl_model
    import mdsq_pkg::*;
(
    // clock and handshake
    input wire logic i_clock,
    input wire logic i_ready,
    input wire logic i_force,
    // word stream
    output logic o_valid,
    output logic [MDSQ_WORD_W-1:0] o_data
);
    localparam int GAP = 25; // one word per 27 clocks, about 370k words/s at 10 MHz
    logic [MDSQ_WORD_W-1:0] q[$]; // words waiting, channel in top nibble
    logic ok;
    // hold each word until taken; force pushes refused words through
    initial begin
        o_valid = 1'b0;
        o_data = 32'h0000_0000;
        forever begin
            @(posedge i_clock);
            if (q.size() > 0) begin
                #1;
                o_valid = 1'b1;
                o_data = q.pop_front();
                forever begin
                    @(negedge i_clock) ok = i_ready || i_force;
                    @(posedge i_clock);
                    if (ok) break;
                end
                #1;
                o_valid = 1'b0;
                o_data = ~o_data; // released lines do not keep the word
                repeat (GAP) @(posedge i_clock);
            end
        end
    end
endmodule

// *** mdsq_sequencer_tb.sv ***
// self-checking bench for the multichannel output sequencer
`timescale 1ns/100ps
module mdsq_sequencer_tb
    import mdsq_pkg::*;
;
    localparam int AW = 4; // 16-word buffer so it can be filled
    localparam int DW = 8;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic wr_valid, force_wr, ring_mode, run, page_change, upd, page, wr_ready, underrun, overflow;
    logic [MDSQ_WORD_W-1:0] wr_data;
    logic [AW-2:0] ring_len;
    logic [3:0] trig;
    logic [3:0] gen_load;
    logic [MDSQ_PHASE_W-1:0] gen_phase;
    logic [9*MDSQ_SEL_W-1:0] src_sel;
    logic [MDSQ_NUM_CONV*16-1:0] scale;
    logic [MDSQ_NUM_CONV*MDSQ_DATA_W-1:0] offset, conv;
    logic [DW-1:0] dout;
    logic [DW/8-1:0] oe_n;
    int bad_count = 0;
    int n_tests = 0;
    // ------------------------------------------------------------
    // design, controller model, clock
    // ------------------------------------------------------------
    mdsq_sequencer #(.ADDR_W(AW), .DOUT_W(DW)) DUT (
        .i_clock(i_clock), .i_rst(i_rst), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
        .i_ring_mode(ring_mode), .i_run(run), .i_page_change(page_change),
        .i_ring_length(ring_len), .i_trig_chan(trig), .i_rate_hz(18'h2_EE00),
        .i_gen_load(gen_load), .i_gen_phase(gen_phase), .i_gen_step(32'h0000_0000),
        .i_src_sel(src_sel), .i_scale(scale), .i_offset(offset), .o_conv_data(conv),
        .o_conv_update(upd), .o_dout(dout), .o_dout_oe_n(oe_n), .o_page_playing(page),
        .o_wr_ready(wr_ready), .o_underrun(underrun), .o_overflow(overflow)
    );
    mdsq_ctl_model ctl (.i_clock(i_clock), .i_ready(wr_ready), .i_force(force_wr),
        .o_valid(wr_valid), .o_data(wr_data));
    initial forever #50 i_clock = ~i_clock;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge i_clock);
        #1;
    endtask
    task automatic do_reset();
        i_rst = 1'b1;
        repeat (4) step();
        i_rst = 1'b0;
    endtask
    task automatic put(input logic [3:0] ch, input logic [23:0] d);
        ctl.q.push_back({ch, 4'h0, d});
    endtask
    // bounded wait until the model has handed over every word
    task automatic idle();
        for (int i = 0; i < 3000; i++) begin
            if (ctl.q.size() == 0 && wr_valid === 1'b0) return;
            step();
        end
        bad_count++;
        conclude();
    endtask
    // bounded wait for a strobe, then let data and enables land
    task automatic wait_upd();
        for (int i = 0; i < 1000; i++) begin
            step();
            if (upd === 1'b1) begin
                repeat (3) step();
                return;
            end
        end
        bad_count++;
        conclude();
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {force_wr, ring_mode, run, page_change} = 4'h0;
        gen_load = 4'h0;
        ring_len = '0;
        trig = 4'h9;
        gen_phase = 32'h0000_0000;
        src_sel = '0;
        scale = {{7{16'h8000}}, 16'h4000}; // channel 1 at half scale
        offset = {{7{24'h00_0000}}, 24'h00_0100};
        do_reset();
        check("conv", 32'(|conv), 0);
        check("oe_n", oe_n, 1);
        check("flags", {underrun, overflow}, 0);
        // full streaming frame closed by the digital word
        for (int k = 1; k <= 8; k++) put(k[3:0], k * 24'h00_0800);
        put(4'h9, 24'h01_00A5); // low byte driven
        idle();
        run = 1'b1;
        wait_upd();
        check("conv1", conv[23:0], 32'h0000_0500);
        for (int k = 2; k <= 8; k++) check("conv", conv[(k-1)*24 +: 24], k * 32'h0000_0800);
        check("dout", dout, 32'h0000_00A5);
        check("oe_n", oe_n, 0);
        // buffer runs dry: outputs hold, underrun is flagged
        for (int i = 0; i < 600 && underrun !== 1'b1; i++) step();
        check("underrun", underrun, 1);
        check("conv2", conv[47:24], 32'h0000_1000);
        // trigger mid-frame, digital back to high-Z, output 8 from a generator
        run = 1'b0;
        src_sel[31:28] = 4'h1;
        src_sel[27:24] = 4'h5; // output 7 from the same generator's cosine
        gen_load = 4'h1;
        step();
        gen_load = 4'h0;
        trig = 4'h2;
        put(4'h9, 24'h00_005A);
        put(4'h2, 24'h00_0222);
        put(4'h3, 24'h00_0333);
        idle();
        run = 1'b1;
        wait_upd();
        check("conv2", conv[47:24], 32'h0000_0222);
        check("conv3", conv[71:48], 32'h0000_1800);
        check("conv8", conv[191:168], 0);
        check("conv7", conv[167:144], 32'h007F_FFFF);
        check("dout", dout, 32'h0000_005A);
        check("oe_n", oe_n, 1);
        // fill the buffer past its depth with the sequencer stopped
        run = 1'b0;
        force_wr = 1'b1;
        for (int k = 0; k < 18; k++) put(4'h1, 24'h00_0001);
        idle();
        check("overflow", overflow, 1);
        check("wr_ready", wr_ready, 0);
        // ring mode: fill the idle page, swap, replay cyclically
        force_wr = 1'b0;
        do_reset();
        ring_mode = 1'b1;
        ring_len = 3'h3;
        trig = 4'h1;
        for (int k = 1; k <= 4; k++) put(4'h1, 24'h00_0010 + k);
        idle();
        run = 1'b1;
        page_change = 1'b1;
        step();
        page_change = 1'b0;
        for (int i = 0; i < 1000 && page !== 1'b1; i++) step();
        check("page", page, 1);
        wait_upd();
        // channel 1 still at half scale plus its offset
        check("ring first", conv[23:0], 32'h0000_0108);
        repeat (4) wait_upd();
        check("ring wrap", conv[23:0], 32'h0000_0108);
        conclude();
    end
    // hang guard
    initial begin
        #9_000_000;
        bad_count++;
        conclude();
    end
endmodule
